// ===== src/rpu_top.sv
// Region protection unit: area compare, permission check, attributes, aborts
`timescale 1ns/100ps
module rpu_top
    import rpu_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire rpu_cp_req_t i_cp_req,
    output logic [31:0] o_cp_rdata,
    output logic o_cp_rvalid,
    input wire rpu_acc_req_t i_acc,
    input wire logic i_cache_hit,
    input wire logic i_ext_done,
    input wire logic i_fill_word_req,
    input wire logic i_fill_last,
    input wire logic i_external_abort_in,
    output logic o_abort,
    output logic o_ext_start,
    output logic o_ext_active,
    output logic o_use_wbuf,
    output logic o_line_fill,
    output logic o_purge_line,
    output logic o_hit_valid,
    output logic [2:0] o_hit_area,
    output logic [3:0] o_ctrl
);
    // Descriptor and attribute registers
    logic [31:0] desc_ff [RPU_NUM_AREAS];
    logic [3:0] ctrl_ff;
    logic [7:0] cacheable_ff;
    logic [7:0] bufferable_ff;
    logic [15:0] perm_ff;
    logic [31:0] cp_rdata_ff;
    logic cp_rvalid_ff;
    rpu_state_t state_ff;
    rpu_state_t nxt_state;
    logic abort_ff;
    logic purge_ff;

    // Permission decode, shared by every access
    function automatic logic perm_ok(input logic [1:0] ap, input logic user,
                                     input logic write);
        case (ap)
            RPU_AP_NONE: perm_ok = 1'b0;
            RPU_AP_SUPV: perm_ok = !user;
            RPU_AP_USER_RO: perm_ok = !user || !write;
            RPU_AP_FULL: perm_ok = 1'b1;
            default: perm_ok = 1'b0;
        endcase
    endfunction : perm_ok

    // Per-area match; lower address bits below size are masked
    logic [7:0] area_hit;
    genvar g;
    generate
        for (g = 0; g < RPU_NUM_AREAS; g++) begin : g_area
            wire logic [4:0] size_code = desc_ff[g][RPU_DESC_SIZE_LSB +: 5];
            // Undefined codes below 4KB are treated as 4KB
            wire logic [4:0] size_eff = (size_code < RPU_SIZE_MIN) ? RPU_SIZE_MIN : size_code;
            // Six-bit sum so the 4GB code reaches bit 32 and masks every address bit
            wire logic [32:0] span = 33'h1 << (6'(size_eff) + 6'h1);
            wire logic [31:0] keep = ~(span[31:0] - 32'h1);
            wire logic [31:0] base = {desc_ff[g][31:RPU_DESC_BASE_LSB], 12'h000};
            assign area_hit[g] = desc_ff[g][RPU_DESC_EN_BIT] &&
                ((i_acc.addr & keep) == (base & keep));
        end
    endgenerate

    // Priority select: highest index wins
    logic [2:0] sel_area;
    always_comb begin
        sel_area = 3'h0;
        for (int i = 0; i < RPU_NUM_AREAS; i++) begin
            if (area_hit[i]) begin
                sel_area = 3'(i);
            end
        end
    end

    // Attribute and permission selection; disabled unit means full access
    wire logic prot_en = ctrl_ff[RPU_CTRL_PROT_BIT];
    wire logic any_hit = |area_hit;
    wire logic [1:0] sel_ap = perm_ff[{sel_area, 1'b0} +: 2];
    wire logic allowed = !prot_en ||
        (any_hit && perm_ok(sel_ap, i_acc.user, i_acc.write));
    wire logic sel_c = prot_en && cacheable_ff[sel_area];
    wire logic sel_b = prot_en && bufferable_ff[sel_area];
    // Locked write phase is never buffered
    wire logic buf_wr = i_acc.write && !i_acc.locked && sel_b &&
        ctrl_ff[RPU_CTRL_WBUF_BIT];
    wire logic fill_rd = !i_acc.write && sel_c && ctrl_ff[RPU_CTRL_CACHE_BIT] &&
        !i_cache_hit;
    wire logic new_acc = i_acc.valid && state_ff == RPU_IDLE;

    // Access sequencing; the check gates the start in the same cycle
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            RPU_IDLE: begin
                if (new_acc && allowed && !buf_wr && !(i_acc.write == 1'b0 && i_cache_hit
                    && sel_c && ctrl_ff[RPU_CTRL_CACHE_BIT])) begin
                    nxt_state = fill_rd ? RPU_FILL : RPU_EXT;
                end
            end
            RPU_EXT: begin
                if (i_external_abort_in) begin
                    nxt_state = RPU_IDLE;
                end else if (i_ext_done) begin
                    nxt_state = (i_acc.locked && !i_acc.write) ? RPU_LOCK_WR : RPU_IDLE;
                end
            end
            RPU_LOCK_WR: begin
                if (i_external_abort_in || i_ext_done) begin
                    nxt_state = RPU_IDLE;
                end
            end
            RPU_FILL: begin
                if (i_fill_last || i_external_abort_in) begin
                    nxt_state = RPU_IDLE;
                end
            end
            default: nxt_state = RPU_IDLE;
        endcase
    end

    // External start only for permitted, unbuffered accesses that are not read hits in a cacheable area with the cache enabled
    assign o_ext_start = (state_ff == RPU_IDLE) && (nxt_state != RPU_IDLE);
    assign o_ext_active = (state_ff != RPU_IDLE);
    assign o_use_wbuf = new_acc && allowed && buf_wr;
    assign o_line_fill = new_acc && allowed && fill_rd;
    assign o_hit_valid = prot_en && any_hit;
    assign o_hit_area = sel_area;

    // Abort and purge flags
    wire logic prot_abort = new_acc && !allowed;
    wire logic ext_abort = i_external_abort_in && ((state_ff == RPU_EXT) ||
        (state_ff == RPU_LOCK_WR) || (state_ff == RPU_FILL && i_fill_word_req));
    wire logic fill_purge = (state_ff == RPU_FILL) && i_external_abort_in;

    // Access state and abort registers
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_ff <= RPU_IDLE;
            abort_ff <= 1'b0;
            purge_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            abort_ff <= prot_abort || ext_abort;
            purge_ff <= fill_purge;
        end
    end
    assign o_abort = abort_ff;
    assign o_purge_line = purge_ff;

    // Coprocessor transfer decode
    wire logic cp_wr = i_cp_req.valid && !i_cp_req.dir_read;
    wire logic cp_rd = i_cp_req.valid && i_cp_req.dir_read;
    wire logic area_wr = cp_wr && i_cp_req.target_reg_field == RPU_REG_AREA;

    // Descriptor storage, indexed by the operand field
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            for (int i = 0; i < RPU_NUM_AREAS; i++) begin
                desc_ff[i] <= RPU_DESC_RESET;
            end
        end else if (area_wr) begin
            desc_ff[i_cp_req.area_index_field] <= i_cp_req.wdata;
        end
    end

    // Control and attribute registers; reset disables protection
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ctrl_ff <= RPU_CTRL_RESET;
            cacheable_ff <= RPU_ATTR_RESET;
            bufferable_ff <= RPU_ATTR_RESET;
            perm_ff <= RPU_PERM_RESET;
        end else if (cp_wr) begin
            case (i_cp_req.target_reg_field)
                RPU_REG_CTRL: ctrl_ff <= i_cp_req.wdata[3:0];
                RPU_REG_CACHEABLE: cacheable_ff <= i_cp_req.wdata[7:0];
                RPU_REG_BUFFERABLE: bufferable_ff <= i_cp_req.wdata[7:0];
                RPU_REG_PERM: perm_ff <= i_cp_req.wdata[15:0];
                default: ;
            endcase
        end
    end

    // Read mux; unmapped registers read zero
    logic [31:0] rd_mux;
    always_comb begin
        case (i_cp_req.target_reg_field)
            RPU_REG_CTRL: rd_mux = {28'h0, ctrl_ff};
            RPU_REG_CACHEABLE: rd_mux = {24'h0, cacheable_ff};
            RPU_REG_BUFFERABLE: rd_mux = {24'h0, bufferable_ff};
            RPU_REG_PERM: rd_mux = {16'h0, perm_ff};
            RPU_REG_AREA: rd_mux = desc_ff[i_cp_req.area_index_field];
            default: rd_mux = 32'h0;
        endcase
    end

    // Read data is registered, valid one cycle after the request
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            cp_rdata_ff <= 32'h0;
            cp_rvalid_ff <= 1'b0;
        end else begin
            cp_rdata_ff <= cp_rd ? rd_mux : cp_rdata_ff;
            cp_rvalid_ff <= cp_rd;
        end
    end
    assign o_cp_rdata = cp_rdata_ff;
    assign o_cp_rvalid = cp_rvalid_ff;
    assign o_ctrl = ctrl_ff;
endmodule : rpu_top

// ===== src/rpu_pkg.sv
// Package for the region protection unit: register numbers, fields, types
package rpu_pkg;
    localparam int RPU_NUM_AREAS = 8;
    // Coprocessor register numbers
    localparam logic [3:0] RPU_REG_CTRL = 4'h1;
    localparam logic [3:0] RPU_REG_CACHEABLE = 4'h2;
    localparam logic [3:0] RPU_REG_BUFFERABLE = 4'h3;
    localparam logic [3:0] RPU_REG_PERM = 4'h5;
    localparam logic [3:0] RPU_REG_AREA = 4'h6;
    // Control register bit positions
    localparam int RPU_CTRL_PROT_BIT = 0;
    localparam int RPU_CTRL_CACHE_BIT = 2;
    localparam int RPU_CTRL_WBUF_BIT = 3;
    // Area descriptor field layout
    localparam int RPU_DESC_EN_BIT = 0;
    localparam int RPU_DESC_SIZE_LSB = 1;
    localparam int RPU_DESC_BASE_LSB = 12;
    // Smallest defined size code (4KB), each step doubles
    localparam logic [4:0] RPU_SIZE_MIN = 5'h0b;
    // Reset values
    localparam logic [31:0] RPU_DESC_RESET = 32'h0000_0000;
    localparam logic [3:0] RPU_CTRL_RESET = 4'h0;
    localparam logic [7:0] RPU_ATTR_RESET = 8'h00;
    localparam logic [15:0] RPU_PERM_RESET = 16'h0000;
    // Permission codes
    localparam logic [1:0] RPU_AP_NONE = 2'h0;
    localparam logic [1:0] RPU_AP_SUPV = 2'h1;
    localparam logic [1:0] RPU_AP_USER_RO = 2'h2;
    localparam logic [1:0] RPU_AP_FULL = 2'h3;

    // Coprocessor transfer request
    typedef struct packed {
        logic valid;
        logic dir_read;
        logic [3:0] target_reg_field;
        logic [2:0] area_index_field;
        logic [31:0] wdata;
    } rpu_cp_req_t;

    // Memory access request from the core
    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic write;
        logic user;
        logic locked;
    } rpu_acc_req_t;

    // Fill/access progress from the cache and bus side
    typedef enum {
        RPU_IDLE,
        RPU_EXT,
        RPU_FILL,
        RPU_LOCK_WR
    } rpu_state_t;
endpackage : rpu_pkg

// ===== verif/rpu_monitor.sv
// Port checker for the region protection unit
`timescale 1ns/100ps
module rpu_monitor
    import rpu_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire rpu_cp_req_t i_cp_req,
    input wire logic o_cp_rvalid,
    input wire rpu_acc_req_t i_acc,
    input wire logic i_cache_hit,
    input wire logic i_external_abort_in,
    input wire logic o_abort,
    input wire logic o_ext_start,
    input wire logic o_ext_active,
    input wire logic o_use_wbuf,
    input wire logic o_line_fill,
    input wire logic o_purge_line,
    input wire logic o_hit_valid,
    input wire logic [3:0] o_ctrl
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    property p_rd; i_cp_req.valid && i_cp_req.dir_read |=> o_cp_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("read answer missing");
    property p_rsrc; o_cp_rvalid |-> $past(i_cp_req.valid && i_cp_req.dir_read); endproperty
    a_rsrc: assert property (p_rsrc) else $error("read answer without request");
    property p_off; i_acc.valid && !o_ctrl[0] |-> !o_hit_valid && !o_use_wbuf && !o_line_fill;
    endproperty
    a_off: assert property (p_off) else $error("attributes used while off");
    property p_wbuf; o_use_wbuf |-> i_acc.write && o_ctrl[3] && o_ctrl[0]; endproperty
    a_wbuf: assert property (p_wbuf) else $error("buffer used wrongly");
    property p_fill; o_line_fill |-> !i_acc.write && o_ctrl[2] && !i_cache_hit; endproperty
    a_fill: assert property (p_fill) else $error("fill started wrongly");
    property p_miss; i_acc.valid && o_ctrl[0] && !o_hit_valid |-> !o_ext_start && !o_line_fill;
    endproperty
    a_miss: assert property (p_miss) else $error("unmapped access reached bus");
    property p_xab; o_ext_active && i_external_abort_in |=> o_abort || o_purge_line; endproperty
    a_xab: assert property (p_xab) else $error("external abort ignored");
    property p_ctl; i_cp_req.valid && !i_cp_req.dir_read && i_cp_req.target_reg_field == 4'h1
        |=> o_ctrl == $past(i_cp_req.wdata[3:0]); endproperty
    a_ctl: assert property (p_ctl) else $error("control write lost");
endmodule : rpu_monitor

bind rpu_top rpu_monitor u_mon (.i_clk, .i_reset, .i_cp_req, .o_cp_rvalid, .i_acc, .i_cache_hit,
    .i_external_abort_in, .o_abort, .o_ext_start, .o_ext_active, .o_use_wbuf, .o_line_fill,
    .o_purge_line, .o_hit_valid, .o_ctrl);

// ===== verif/rpu_mem_model.sv
// External memory model: ends or aborts each access, quick or slow
`timescale 1ns/100ps
module rpu_mem_model (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_active,
    input wire logic i_slow,
    input wire logic i_inject,
    output logic o_done,
    output logic o_abort_in
);
    logic [1:0] wait_ff;
    // One answer pulse per cycle; guard stops a double answer
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            {o_done, o_abort_in, wait_ff} <= 4'h0;
        end else begin
            o_done <= 1'b0;
            o_abort_in <= 1'b0;
            if (!i_active || o_done || o_abort_in) begin
                wait_ff <= {i_slow, 1'b1};
            end else if (wait_ff != 2'h0) begin
                wait_ff <= wait_ff - 2'h1;
            end else begin
                o_done <= !i_inject;
                o_abort_in <= i_inject;
            end
        end
    end
endmodule : rpu_mem_model

// ===== verif/rpu_top_tb.sv
// Testbench for the region protection unit
`timescale 1ns/100ps
module rpu_top_tb;
    import rpu_pkg::*;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    rpu_cp_req_t cp_r = '0;
    rpu_acc_req_t acc_r = '0;
    logic slow = 1'b0, inject = 1'b0, word_req = 1'b1, first_ff = 1'b0, hit = 1'b0;
    logic o_cp_rvalid, o_abort, o_ext_start, o_ext_active, o_use_wbuf, o_line_fill;
    logic o_purge_line, o_hit_valid, done, ab_in;
    logic [31:0] o_cp_rdata;
    logic [2:0] o_hit_area;
    logic [3:0] o_ctrl;
    logic [31:0] exp_q[$];
    int mismatches = 0, checked = 0, cycles = 0;
    localparam logic [31:0] AB = 32'h0000_0ab0;
    localparam logic [31:0] PG = 32'h0000_0bc0;
    always #4 i_clk = ~i_clk;
    rpu_top DUT (.i_clk, .i_reset, .i_cp_req(cp_r), .o_cp_rdata, .o_cp_rvalid, .i_acc(acc_r),
        .i_cache_hit(hit), .i_ext_done(done), .i_fill_word_req(word_req), .i_fill_last(done),
        .i_external_abort_in(ab_in), .o_abort, .o_ext_start, .o_ext_active, .o_use_wbuf,
        .o_line_fill, .o_purge_line, .o_hit_valid, .o_hit_area, .o_ctrl);
    rpu_mem_model u_mem (.i_clk, .i_reset, .i_active(o_ext_active), .i_slow(slow),
        .i_inject(inject), .o_done(done), .o_abort_in(ab_in));
    function automatic logic [31:0] nt(input logic h, input logic [2:0] a, input logic w, f);
        return {26'h0, h, a, w, f};
    endfunction : nt
    task automatic test_done();
        if (exp_q.size() != 0) begin
            mismatches++;
            $display("FAIL queue exp 0 got %0d", exp_q.size());
        end
        if (mismatches == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    task automatic cmp(input logic [31:0] seen);
        logic [31:0] e;
        e = exp_q.size() ? exp_q.pop_front() : 32'hffff_ffff;
        checked++;
        if (seen !== e) begin
            mismatches++;
            $display("FAIL result exp %h got %h", e, seen);
        end
    endtask : cmp
    // Results land on the falling edge, well clear of input changes
    always @(negedge i_clk) begin
        cycles++;
        if (cycles > 5000) begin
            mismatches++;
            test_done();
        end
        if (o_cp_rvalid === 1'b1) cmp(o_cp_rdata);
        if (o_abort === 1'b1) cmp(AB);
        if (o_purge_line === 1'b1) cmp(PG);
        if (acc_r.valid && !first_ff && (o_ext_start | o_use_wbuf | o_line_fill) === 1'b1)
            cmp(nt(o_hit_valid, o_hit_area & {3{o_hit_valid}}, o_use_wbuf, o_line_fill));
        first_ff = acc_r.valid;
    end
    task automatic cp(input logic rd, input logic [3:0] r, input logic [2:0] x,
                      input logic [31:0] d);
        @(posedge i_clk);
        cp_r <= '{1'b1, rd, r, x, d};
        @(posedge i_clk);
        cp_r.valid <= 1'b0;
    endtask : cp
    // Access held until the design is idle again, so it is never taken twice
    // Bit 0 of ab expects an abort, bit 1 a line purge in the same cycle
    task automatic acc(input logic [31:0] a, input logic w, u, input logic [31:0] e,
                       input logic [1:0] ab);
        int n;
        exp_q.push_back(e);
        if (ab[0]) exp_q.push_back(AB);
        if (ab[1]) exp_q.push_back(PG);
        @(posedge i_clk);
        acc_r <= '{1'b1, a, w, u, 1'b0};
        @(negedge i_clk);
        if (o_ext_start === 1'b1 || o_line_fill === 1'b1)
            for (n = 0; n < 20 && done !== 1'b1 && ab_in !== 1'b1; n++) @(negedge i_clk);
        @(posedge i_clk);
        acc_r.valid <= 1'b0;
        repeat (2) @(posedge i_clk);
    endtask : acc
    initial begin
        int i, c, k;
        logic [31:0] d[8];
        logic u, w, ok;
        void'($urandom(73625));
        repeat (4) @(posedge i_clk);
        i_reset <= 1'b0;
        exp_q.push_back(32'h0);
        cp(1, RPU_REG_CTRL, 0, 0);
        acc($urandom, 1, 1, nt(0, 0, 0, 0), 0);
        for (i = 0; i < 8; i++) d[i] = $urandom & 32'hffff_fffe;
        d[0] = 32'h0000_003f;
        d[5] = 32'h0000_801b;
        d[6] = 32'h0000_a016;
        d[7] = 32'h0000_9017;
        for (i = 0; i < 8; i++) cp(0, RPU_REG_AREA, i[2:0], d[i]);
        for (i = 0; i < 8; i++) begin
            exp_q.push_back(d[i]);
            cp(1, RPU_REG_AREA, i[2:0], 0);
        end
        cp(0, RPU_REG_CACHEABLE, 0, 32'h20);
        cp(0, RPU_REG_BUFFERABLE, 0, 32'h20);
        cp(0, RPU_REG_PERM, 0, 32'h3);
        cp(0, RPU_REG_CTRL, 0, 32'hd);
        for (c = 0; c < 4; c++) begin
            cp(0, RPU_REG_PERM, 0, 32'h3 | (c << 10));
            for (k = 0; k < 4; k++) begin
                u = k[1];
                w = k[0];
                slow <= 1'($urandom);
                ok = c == 3 || (c != 0 && !u) || (c == 2 && !w);
                acc(32'ha000 | ($urandom & 32'hffc), w, u, ok ? nt(1, 5, w, !w) : AB, 0);
            end
        end
        acc(32'h0000_9000, 0, 0, AB, 0);
        acc(32'h0001_0000, 0, 1, nt(1, 0, 0, 0), 0);
        // A cache hit in an uncacheable area still goes out to memory
        hit <= 1'b1;
        acc(32'h0001_0008, 0, 0, nt(1, 0, 0, 0), 0);
        hit <= 1'b0;
        inject <= 1'b1;
        acc(32'h0001_0004, 0, 0, nt(1, 0, 0, 0), 2'h1);
        for (k = 0; k < 2; k++) begin
            word_req <= k[0];
            acc(32'h0000_8000, 0, 0, nt(1, 5, 0, 1), {1'b1, k[0]});
        end
        inject <= 1'b0;
        cp(0, RPU_REG_AREA, 0, 0);
        acc(32'h0001_0000, 1, 0, AB, 0);
        exp_q.push_back(32'h0);
        cp(1, 4'h4, 0, 0);
        cp(0, RPU_REG_CTRL, 0, 0);
        exp_q.push_back(32'h0);
        cp(1, RPU_REG_CTRL, 0, 0);
        repeat (4) @(posedge i_clk);
        test_done();
    end
endmodule : rpu_top_tb
